// [hw/bor_pkg.sv]
package bor_pkg;
   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] BOR_ADDR_MAIN = 8'h10; // main setting
   localparam logic [7:0] BOR_ADDR_MODE = 8'h11; // mode control
   localparam logic [7:0] BOR_ADDR_STBY = 8'h12; // standby level

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BOR_MAIN_EN_BIT = 7; // converter on/off
   localparam int BOR_MAIN_RPL_BIT = 6; // light-load ripple select
   localparam int BOR_MAIN_PFM_BIT = 5; // light-load mode disable
   localparam int BOR_VCODE_LSB = 0; // voltage code, five bits
   localparam int BOR_MODE_STBY_BIT = 6; // standby mode on
   localparam int BOR_MODE_DISCH_BIT = 5; // discharge switch
   localparam int BOR_MODE_PH_LSB = 3; // phase field, two bits
   localparam int BOR_MODE_SLEW_LSB = 0; // slew field, three bits
   localparam int BOR_STBY_PIN_LSB = 5; // pin levels, three bits

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] BOR_MAIN_RESET = 8'h00; // converter off, code 0
   localparam logic [7:0] BOR_MODE_RESET = 8'h06; // slew code 110
   localparam logic [4:0] BOR_STBY_RESET = 5'h00; // standby code 0

   // ----------------------------------------------------------------
   // slew codes and ramp rates, in units of 0.01 mV/us
   // ----------------------------------------------------------------
   localparam logic [2:0] BOR_SLEW_C0 = 3'h0;
   localparam logic [2:0] BOR_SLEW_C1 = 3'h1;
   localparam logic [2:0] BOR_SLEW_C2 = 3'h2;
   localparam logic [2:0] BOR_SLEW_C3 = 3'h3;
   localparam logic [2:0] BOR_SLEW_C4 = 3'h4;
   localparam logic [2:0] BOR_SLEW_C5 = 3'h5;
   localparam logic [2:0] BOR_SLEW_C6 = 3'h6;
   localparam logic [2:0] BOR_SLEW_IMM = 3'h7; // no ramp
   localparam logic [15:0] BOR_RATE_C0 = 16'h0C00; // 30.72
   localparam logic [15:0] BOR_RATE_C1 = 16'h0030; // 0.48
   localparam logic [15:0] BOR_RATE_C2 = 16'h0060; // 0.96
   localparam logic [15:0] BOR_RATE_C3 = 16'h00C0; // 1.92
   localparam logic [15:0] BOR_RATE_C4 = 16'h0180; // 3.84
   localparam logic [15:0] BOR_RATE_C5 = 16'h0300; // 7.68
   localparam logic [15:0] BOR_RATE_C6 = 16'h0600; // 15.36
   localparam logic [15:0] BOR_RATE_IMM = 16'h0000; // immediate

   // ----------------------------------------------------------------
   // phase codes
   // ----------------------------------------------------------------
   localparam logic [1:0] BOR_PH_0 = 2'h0;
   localparam logic [1:0] BOR_PH_90 = 2'h1;
   localparam logic [1:0] BOR_PH_180 = 2'h2;
   localparam logic [1:0] BOR_PH_270 = 2'h3;

   // converter control bundle toward the analog core
   typedef struct packed {
      logic enable; // converter on
      logic ripple_min; // 1: minimise ripple, 0: maximise efficiency
      logic pwm_only; // 1: pwm only, 0: auto pwm/pfm
      logic standby; // standby mode on
      logic discharge; // output discharge switch on
      logic [4:0] vcode; // active voltage code
      logic slew_immediate; // voltage steps without ramp
      logic [15:0] slew_rate; // ramp rate, 0.01 mV/us
      logic [1:0] phase; // clock phase code
   } bor_ctrl_t;
endpackage

// [hw/bor_regs.sv]
`timescale 1ns/1ps
// Function
// - enable bit switches converter on or off
// - ripple bit picks efficiency or low ripple
// - mode bit allows pfm or forces pwm
// - slew codes 001,011,101 give 0.48,1.92,7.68
// - slew in mV/us, resets 15.36, immediate code
// - registers at fixed addresses, access per byte
module bor_regs
   import bor_pkg::*;
(
   input wire logic clk_in, // 50 MHz system clock
   input wire logic rst_n_in, // asynchronous reset, active low
   input wire logic [7:0] reg_addr_in, // register address from i2c engine
   input wire logic [7:0] reg_wdata_in, // write data
   input wire logic reg_wr_in, // one-cycle write strobe
   input wire logic reg_rd_in, // one-cycle read strobe
   output logic [7:0] reg_rdata_out, // read data, registered
   input wire logic [2:0] pin_level_in, // raw levels of pins three..one
   input wire logic ref_clk_in, // reference clock from pin
   output bor_ctrl_t ctrl_out, // converter controls, registered
   output logic sw_clk_out // phase-shifted switching clock
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [7:0] main_reg, main_next; // main setting
   logic [7:0] mode_reg, mode_next; // mode control, bit 7 unused
   logic [4:0] stby_reg, stby_next; // standby voltage code
   logic [7:0] rdata_reg, rdata_next; // read data holding
   bor_ctrl_t ctrl_reg, ctrl_next; // decoded controls

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] sy1_reg, sy1_next; // first stage, read only by second
   logic [3:0] sy2_reg, sy2_next; // second stage
   logic [3:0] sy3_reg, sy3_next; // third stage
   logic [3:0] lvl_reg, lvl_next; // filtered levels, bit 3 is ref clock

   // ----------------------------------------------------------------
   // phase shifter state
   // ----------------------------------------------------------------
   logic [15:0] cnt_reg, cnt_next; // cycles since last ref rise
   logic [15:0] per_reg, per_next; // measured ref period
   logic ref_q_reg, ref_q_next; // last filtered ref level
   logic sw_reg, sw_next; // switching clock output

   // ----------------------------------------------------------------
   // synchroniser logic
   // ----------------------------------------------------------------
   // synchroniser next values: a level counts once stages two and three agree
   always_comb begin
      sy1_next = {ref_clk_in, pin_level_in};
      sy2_next = sy1_reg;
      sy3_next = sy2_reg;
      lvl_next = lvl_reg;
      for (int i = 0; i < 4; i++) begin
         if (sy2_reg[i] == sy3_reg[i]) begin
            lvl_next[i] = sy2_reg[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   // reads look at the _reg values, so a write and a read in one cycle return the old value
   // register writes and reads
   always_comb begin
      main_next = main_reg;
      mode_next = mode_reg;
      stby_next = stby_reg;
      rdata_next = rdata_reg;
      if (reg_wr_in) begin
         if (reg_addr_in == BOR_ADDR_MAIN) begin
            main_next = reg_wdata_in;
         end else if (reg_addr_in == BOR_ADDR_MODE) begin
            // bit 7 is unused and keeps zero
            mode_next = {1'b0, reg_wdata_in[6:0]};
         end else if (reg_addr_in == BOR_ADDR_STBY) begin
            // pin level bits are read only
            stby_next = reg_wdata_in[4:0];
         end
      end
      if (reg_rd_in) begin
         if (reg_addr_in == BOR_ADDR_MAIN) begin
            rdata_next = main_reg;
         end else if (reg_addr_in == BOR_ADDR_MODE) begin
            rdata_next = mode_reg;
         end else if (reg_addr_in == BOR_ADDR_STBY) begin
            rdata_next = {lvl_reg[2:0], stby_reg};
         end else begin
            // unmapped addresses read as zero
            rdata_next = 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------
   // converter control decode
   // ----------------------------------------------------------------
   // decode of controls toward the converter
   always_comb begin
      ctrl_next.enable = main_reg[BOR_MAIN_EN_BIT];
      ctrl_next.ripple_min = main_reg[BOR_MAIN_RPL_BIT];
      ctrl_next.pwm_only = main_reg[BOR_MAIN_PFM_BIT];
      ctrl_next.standby = mode_reg[BOR_MODE_STBY_BIT];
      ctrl_next.discharge = mode_reg[BOR_MODE_DISCH_BIT];
      // standby mode swaps in the standby code
      if (mode_reg[BOR_MODE_STBY_BIT]) begin
         ctrl_next.vcode = stby_reg;
      end else begin
         ctrl_next.vcode = main_reg[BOR_VCODE_LSB +: 5];
      end
      ctrl_next.phase = mode_reg[BOR_MODE_PH_LSB +: 2];
      ctrl_next.slew_immediate = 1'b0;
      case (mode_reg[BOR_MODE_SLEW_LSB +: 3])
         BOR_SLEW_C0: ctrl_next.slew_rate = BOR_RATE_C0;
         BOR_SLEW_C1: ctrl_next.slew_rate = BOR_RATE_C1;
         BOR_SLEW_C2: ctrl_next.slew_rate = BOR_RATE_C2;
         BOR_SLEW_C3: ctrl_next.slew_rate = BOR_RATE_C3;
         BOR_SLEW_C4: ctrl_next.slew_rate = BOR_RATE_C4;
         BOR_SLEW_C5: ctrl_next.slew_rate = BOR_RATE_C5;
         BOR_SLEW_C6: ctrl_next.slew_rate = BOR_RATE_C6;
         default: begin
            ctrl_next.slew_rate = BOR_RATE_IMM;
            ctrl_next.slew_immediate = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // switching clock phase shifter
   // ----------------------------------------------------------------
   // phase shifter: measure ref period, replay it delayed by zero to three quarter periods per phase code
   always_comb begin
      logic [15:0] off; // delay in cycles
      logic [15:0] pos; // position within delayed period
      off = 16'h0000;
      pos = 16'h0000;
      ref_q_next = lvl_reg[3];
      per_next = per_reg;
      if (lvl_reg[3] && !ref_q_reg) begin
         // rising edge: latch period, restart count
         per_next = 16'(cnt_reg + 16'h0001);
         cnt_next = 16'h0000;
      end else if (cnt_reg != 16'hFFFF) begin
         cnt_next = 16'(cnt_reg + 16'h0001);
      end else begin
         // saturate while the reference stands still
         cnt_next = cnt_reg;
      end
      case (mode_reg[BOR_MODE_PH_LSB +: 2])
         BOR_PH_0: off = 16'h0000;
         BOR_PH_90: off = 16'(per_reg >> 2);
         BOR_PH_180: off = 16'(per_reg >> 1);
         BOR_PH_270: off = 16'((per_reg >> 1) + (per_reg >> 2));
         default: off = 16'h0000;
      endcase
      if (cnt_reg >= off) begin
         pos = 16'(cnt_reg - off);
      end else begin
         pos = 16'(cnt_reg + per_reg - off);
      end
      // high for the first half of the delayed period; a change of
      // period shows only after a full reference cycle is measured
      sw_next = (pos < (per_reg >> 1));
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   // register all state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_reg <= BOR_MAIN_RESET;
         mode_reg <= BOR_MODE_RESET;
         stby_reg <= BOR_STBY_RESET;
         rdata_reg <= 8'h00;
         ctrl_reg <= '0;
         sy1_reg <= 4'h0;
         sy2_reg <= 4'h0;
         sy3_reg <= 4'h0;
         lvl_reg <= 4'h0;
         cnt_reg <= 16'h0000;
         per_reg <= 16'h0000;
         ref_q_reg <= 1'b0;
         sw_reg <= 1'b0;
      end else begin
         main_reg <= main_next;
         mode_reg <= mode_next;
         stby_reg <= stby_next;
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         sy1_reg <= sy1_next;
         sy2_reg <= sy2_next;
         sy3_reg <= sy3_next;
         lvl_reg <= lvl_next;
         cnt_reg <= cnt_next;
         per_reg <= per_next;
         ref_q_reg <= ref_q_next;
         sw_reg <= sw_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // every output comes straight from a flip-flop, so the analog side sees no glitches
   assign reg_rdata_out = rdata_reg;
   assign ctrl_out = ctrl_reg;
   assign sw_clk_out = sw_reg;
endmodule // bor_regs

// [verif/bor_regs_properties.sv]
`timescale 1ns/1ps
module bor_regs_properties
   import bor_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire bor_ctrl_t ctrl_out
);
   // ---------------------------------------------
   // write decode, one clock domain
   // ---------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic wr_main; // write strobe to main setting
   logic wr_mode; // write strobe to mode control
   assign wr_main = reg_wr_in && (reg_addr_in == BOR_ADDR_MAIN);
   assign wr_mode = reg_wr_in && (reg_addr_in == BOR_ADDR_MODE);
   AST_ENABLE: assert property (wr_main |-> ##2 ctrl_out.enable == $past(reg_wdata_in[7], 2))
      else $error("enable does not follow write");
   AST_QUIET: assert property (!reg_wr_in [*2] |=> $stable(ctrl_out))
      else $error("controls moved without a write");
   AST_RIPPLE: assert property (wr_main |-> ##2 ctrl_out.ripple_min == $past(reg_wdata_in[6], 2))
      else $error("ripple select does not follow write");
   AST_PWM: assert property (wr_main |-> ##2 ctrl_out.pwm_only == $past(reg_wdata_in[5], 2))
      else $error("pwm only does not follow write");
   AST_SLEW_LOW: assert property (wr_mode && reg_wdata_in[2:0] == 3'h1 |-> ##2 ctrl_out.slew_rate == 16'h0030)
      else $error("slew code one gives wrong rate");
   AST_IMM: assert property (wr_mode && reg_wdata_in[2:0] == 3'h7 |-> ##2 ctrl_out.slew_immediate)
      else $error("immediate code not decoded");
   AST_PHASE: assert property (wr_mode |-> ##2 ctrl_out.phase == $past(reg_wdata_in[4:3], 2))
      else $error("phase does not follow write");
   AST_UNMAPPED: assert property (reg_rd_in && (reg_addr_in < BOR_ADDR_MAIN || reg_addr_in > BOR_ADDR_STBY) |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   // unused mode bit reads zero, data holds
   AST_MODE_B7: assert property (reg_rd_in && reg_addr_in == BOR_ADDR_MODE |=> !reg_rdata_out[7])
      else $error("unused mode bit reads one");
   AST_HOLD: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
endmodule // bor_regs_properties
bind bor_regs bor_regs_properties bor_regs_properties_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ctrl_out(ctrl_out));

// [verif/tb_bor_regs.sv]
`timescale 1ns/1ps
module tb_bor_regs
   import bor_pkg::*;
;
   // ---------------------------------------------
   // stimulus and design
   // ---------------------------------------------
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [7:0] reg_wdata_in = 8'h00;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [2:0] pin_level_in = 3'h0;
   logic ref_clk_in = 1'b0; // reference clock, free running
   logic [3:0] ref_div = 4'h0; // reference divider, period of 16 system clocks
   logic [7:0] reg_rdata_out;
   bor_ctrl_t ctrl_out;
   int error_cnt = 0;
   int checks = 0;
   always #10 clk_in = ~clk_in;
   // reference clock: 16 system clocks a period, so a quarter step is 4 clocks
   always begin
      @(posedge clk_in);
      #1;
      ref_div = ref_div + 4'h1;
      ref_clk_in = ref_div[3];
   end
   logic sw_clk_out;
   bor_regs bor_regs_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .pin_level_in(pin_level_in), .ref_clk_in(ref_clk_in),
      .ctrl_out(ctrl_out), .sw_clk_out(sw_clk_out));
   // ---------------------------------------------
   // shared bus cycles and compare
   // ---------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // write, then one idle edge so the controls have settled on return
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(posedge clk_in);
      #1;
      reg_wr_in = 1'b0;
      @(posedge clk_in);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      #1;
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(posedge clk_in);
      #1;
      reg_rd_in = 1'b0;
      chk("rdata", 16'(e), 16'(reg_rdata_out));
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_reset;
      rd(BOR_ADDR_MAIN, 8'h00);
      rd(BOR_ADDR_MODE, 8'h06);
      rd(BOR_ADDR_STBY, 8'h00);
      chk("slew", 16'h0600, ctrl_out.slew_rate);
      $display("test reset done");
   endtask
   task automatic t_main;
      wr(BOR_ADDR_MAIN, 8'hE5);
      chk("enable", 16'h1, 16'(ctrl_out.enable));
      chk("ripple", 16'h1, 16'(ctrl_out.ripple_min));
      chk("pwm", 16'h1, 16'(ctrl_out.pwm_only));
      rd(BOR_ADDR_MAIN, 8'hE5);
      wr(BOR_ADDR_MAIN, 8'h1A);
      chk("flags", 16'h0, 16'({ctrl_out.enable, ctrl_out.ripple_min, ctrl_out.pwm_only}));
      $display("test main done");
   endtask
   task automatic t_slew;
      logic [15:0] rate [8] = '{16'h0C00, 16'h0030, 16'h0060, 16'h00C0, 16'h0180, 16'h0300,
         16'h0600, 16'h0000};
      for (int i = 0; i < 8; i++) begin
         wr(BOR_ADDR_MODE, 8'(i));
         chk("rate", rate[i], ctrl_out.slew_rate);
         chk("immediate", 16'(i == 7), 16'(ctrl_out.slew_immediate));
      end
      $display("test slew done");
   endtask
   task automatic t_mode;
      for (int p = 0; p < 4; p++) begin
         wr(BOR_ADDR_MODE, 8'(p * 8 + 6));
         chk("phase", 16'(p), 16'(ctrl_out.phase));
      end
      wr(BOR_ADDR_STBY, 8'h0B);
      wr(BOR_ADDR_MODE, 8'hFF);
      rd(BOR_ADDR_MODE, 8'h7F);
      chk("standby", 16'h3, 16'({ctrl_out.standby, ctrl_out.discharge}));
      chk("vcode", 16'h0B, 16'(ctrl_out.vcode));
      $display("test mode done");
   endtask
   task automatic t_pins;
      pin_level_in = 3'h5;
      wr(BOR_ADDR_STBY, 8'hFF);
      repeat (4) @(posedge clk_in);
      rd(BOR_ADDR_STBY, 8'hBF);
      wr(8'h13, 8'hFF);
      rd(8'h13, 8'h00);
      rd(BOR_ADDR_MAIN, 8'h1A);
      $display("test pins done");
   endtask
   // phase steps: the output rise moves a quarter reference period per code
   task automatic t_phase;
      int d0;
      int d;
      int k;
      logic ref_prev;
      logic sw_prev;
      d0 = 0;
      for (int p = 0; p < 4; p++) begin
         wr(BOR_ADDR_MODE, 8'(p * 8 + 6));
         d = -1;
         k = -1;
         ref_prev = 1'b1;
         sw_prev = 1'b1;
         // bounded search: a reference rise, then edges to the next output rise
         for (int n = 0; n < 48; n++) begin
            @(posedge clk_in);
            #3;
            if (k < 0) begin
               if (ref_clk_in && !ref_prev) begin
                  k = 0;
               end
            end else if (d < 0) begin
               k++;
               if (sw_clk_out && !sw_prev) begin
                  d = k;
               end
            end
            ref_prev = ref_clk_in;
            sw_prev = sw_clk_out;
         end
         if (d < 0) begin
            error_cnt++;
            $display("Error sw_clk_out expected a rise seen none");
            give_verdict();
         end
         if (p == 0) begin
            d0 = d;
         end else begin
            chk("phase delay", 16'(4'(p * 4)), 16'(4'(d - d0)));
         end
      end
      $display("test phase done");
   endtask
   // ---------------------------------------------
   // verdict, main sequence, watchdog
   // ---------------------------------------------
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      t_reset();
      t_main();
      t_slew();
      t_mode();
      t_pins();
      t_phase();
      give_verdict();
   end
   initial begin
      #500000;
      error_cnt++;
      give_verdict();
   end
endmodule // tb_bor_regs
